/* File: bench/test_ramp_generator_control.sv */
// testbench: ramp generator control registers and switch sequencing
`timescale 1ns/100ps
module test_ramp_generator_control;
    import rgc_pkg::*;
    // ========================================
    // signals
    logic        sys_clk, nrst, psel, penable, pwrite;  // clock and apb
    logic [11:0] paddr;                                 // apb address
    logic [31:0] pwdata, prdata, rd;                    // apb data
    logic        pready, pslverr, err;                  // apb answer
    logic        rise, fall, sleep;                     // timing inputs
    logic        analog_en, src_sw, sink_sw, dis_sw;    // switch outputs
    int          error_cnt, n_tests, cyc;               // counters
    logic [7:0]  d;                                     // random value
    rgc_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .set_rise_in(rise), .set_fall_in(fall), .sleep_in(sleep),
        .analog_en(analog_en), .src_sw(src_sw), .sink_sw(sink_sw),
        .dis_sw(dis_sw));
    // ========================================
    // clock and hang guard
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // ========================================
    // tasks
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // let outputs settle past an edge
    task automatic wcyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wcyc
    task automatic drv(logic r, logic f, logic [2:0] exp);
        @(posedge sys_clk);
        rise <= r;
        fall <= f;
        wcyc(6);
        chk("switches", {src_sw, sink_sw, dis_sw}, {29'h0, exp});
    endtask : drv
    task automatic wrap_up();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // ========================================
    // main sequence
    initial begin
        sys_clk = 0; nrst = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; rise = 0; fall = 0; sleep = 0;
        error_cnt = 0; n_tests = 0; cyc = 0;
        void'($urandom(62432));
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        apb(0, RGC_OFS_MAIN, 0);
        chk("main reset", rd, 32'h0000_0000);
        chk("mapped err", err, 0);
        apb(0, RGC_OFS_STPOL, 0);
        chk("stat reset", rd, 32'h0000_0000);
        // random writes while disabled, sleep toggling
        repeat (8) begin
            d = 8'($urandom) & 8'h7F;
            sleep <= 1'($urandom);
            apb(1, RGC_OFS_MAIN, {24'h0, d});
            apb(0, RGC_OFS_MAIN, 0);
            chk("main rdbk", rd, {24'h0, d & 8'h3E});
            d = 8'($urandom);
            apb(1, RGC_OFS_STPOL, {24'h0, d});
            apb(0, RGC_OFS_STPOL, 0);
            chk("stat rdbk", rd, {24'h0, d & 8'h03});
        end
        apb(0, 12'h008, 0);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 0);
        apb(1, RGC_OFS_STPOL, 0);
        apb(1, RGC_OFS_MAIN, 32'h0000_0080);
        wcyc(1);
        chk("analog_en", analog_en, 1);
        chk("idle sw", {src_sw, sink_sw, dis_sw}, 3'b001);
        wcyc(20);
        apb(0, RGC_OFS_STPOL, 0);
        chk("ready", rd, 32'h0000_0004);
        apb(1, RGC_OFS_MAIN, 32'h0000_0081);  // slope, running
        drv(1, 0, 3'b010);
        drv(1, 1, 3'b001);
        drv(1, 0, 3'b010);
        apb(1, RGC_OFS_MAIN, 32'h0000_0089);  // rising ramp
        wcyc(6);
        chk("rise mode", {src_sw, sink_sw, dis_sw}, 3'b100);
        apb(1, RGC_OFS_MAIN, 32'h0000_0095);  // alternating, rise edge
        drv(0, 1, 3'b010);
        drv(1, 0, 3'b100);
        drv(1, 1, 3'b010);
        drv(1, 0, 3'b010);
        apb(1, RGC_OFS_STPOL, 32'h0000_0001);  // rise active low
        drv(0, 0, 3'b100);
        apb(1, RGC_OFS_MAIN, 32'h0000_0000);
        wcyc(1);
        chk("disabled", {analog_en, src_sw, sink_sw, dis_sw}, 0);
        apb(0, RGC_OFS_STPOL, 0);
        chk("ready clr", rd, 32'h0000_0001);
        // one-shot in slope mode with rise held as a level
        apb(1, RGC_OFS_STPOL, 32'h0000_0000);
        rise <= 1'b1;
        fall <= 1'b0;
        apb(1, RGC_OFS_MAIN, 32'h0000_0080);
        wcyc(4);
        apb(1, RGC_OFS_MAIN, 32'h0000_0083);
        wcyc(1);
        chk("os hold", {src_sw, sink_sw, dis_sw}, 3'b001);
        wcyc(RGC_OS_CYC);
        chk("os end", {src_sw, sink_sw, dis_sw}, 3'b010);
        drv(1, 1, 3'b001);
        drv(1, 0, 3'b010);
        // reset in mid-run clears every field
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        wcyc(1);
        chk("rst out", {analog_en, src_sw, sink_sw, dis_sw}, 0);
        apb(0, RGC_OFS_MAIN, 0);
        chk("rst main", rd, 32'h0000_0000);
        wrap_up();
    end
endmodule : test_ramp_generator_control

/* File: design/rgc_pkg.sv */
// package: constants for the ramp generator control block
// Contract
// - one-shot guarantees minimum discharge or ramp time
// - minimum time enable selects internal timing
// - sleep leaves state and operation untouched
// - reset returns to disabled, fields cleared
// - enable bit seven enables the generator
// - fall edge select: edge or level
// - rise edge select: edge or level
// - mode field selects three modes, one reserved
// - run bit forced low while disabled
// - run low while enabled opens sources, closes discharge
// - ready flag reads generator readiness, resets low
// - fall polarity selects active-low falling input
// - rise polarity selects active-low rising input
// - unimplemented bits read zero, writes ignored
// - run rising edge triggers the one-shot
// - edges ignored during one-shot, levels deferred
// - falling input dominates rising input
// - mode decides ramp direction or discharge
package rgc_pkg;
    // ========================================
    // register map
    localparam logic [11:0] RGC_OFS_MAIN  = 12'h000;    // main control
    localparam logic [11:0] RGC_OFS_STPOL = 12'h004;    // status/polarity
    // ========================================
    // main control fields
    localparam int RGC_EN_BIT    = 7;                  // module enable
    localparam int RGC_FALL_TRIGGER_EDGE_SELECT_BIT  = 5;                  // fall edge select
    localparam int RGC_RISE_TRIGGER_EDGE_SELECT_BIT  = 4;                  // rise edge select
    localparam int RGC_MODE_LSB  = 2;                  // mode field low bit
    localparam int RGC_OS_BIT    = 1;                  // minimum time enable
    localparam int RGC_GO_BIT    = 0;                  // run bit
    localparam logic [7:0] RGC_MAIN_WMASK = 8'hBF;     // bit 6 unimplemented
    // status/polarity fields
    localparam int RGC_RDY_BIT   = 2;                  // ready flag
    localparam int RGC_FALL_TRIGGER_POLARITY_BIT  = 1;                  // fall polarity
    localparam int RGC_RISE_TRIGGER_POLARITY_BIT  = 0;                  // rise polarity
    localparam logic [7:0] RGC_MAIN_RST  = 8'h00;      // reset value
    localparam logic [1:0] RGC_POL_RST   = 2'h0;       // reset value
    // ========================================
    // modes
    localparam logic [1:0] RGC_MODE_SLOPE = 2'h0;      // slope compensation
    localparam logic [1:0] RGC_MODE_ALT   = 2'h1;      // alternating
    localparam logic [1:0] RGC_MODE_RISE  = 2'h2;      // rising ramp
    // ========================================
    // timing
    localparam int RGC_CLK_HZ      = 25_000_000;       // system clock
    localparam int RGC_OS_NS       = 50;               // nominal one-shot
    localparam int RGC_OS_CYC      =
        ((RGC_OS_NS * (RGC_CLK_HZ / 1_000_000)) + 999) / 1000 < 1 ? 1 :
        ((RGC_OS_NS * (RGC_CLK_HZ / 1_000_000)) + 999) / 1000;
    localparam int RGC_SETTLE_CYC  = 16;               // ready settle count
    localparam logic [4:0] RGC_OS_LOAD  = 5'(RGC_OS_CYC);
    localparam logic [4:0] RGC_SET_LOAD = 5'(RGC_SETTLE_CYC);
endpackage : rgc_pkg

/* File: design/rgc_top.sv */
// module: ramp generator switch control with apb registers
`timescale 1ns/100ps
module rgc_top
    import rgc_pkg::*;
(
    input  wire logic        sys_clk,      // system clock 25 MHz
    input  wire logic        nrst,         // sync reset, active low
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb enable
    input  wire logic        pwrite,       // apb direction
    input  wire logic [11:0] paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error
    input  wire logic        set_rise_in,  // rising timing source
    input  wire logic        set_fall_in,  // falling timing source
    input  wire logic        sleep_in,     // low power state, no effect
    output logic             analog_en,    // bias and sources powered
    output logic             src_sw,       // current source switch
    output logic             sink_sw,      // current sink switch
    output logic             dis_sw        // discharge switch closed
);
    // ========================================
    // registers
    logic [7:0] main_r;        // main control
    logic [1:0] pol_r;         // polarity bits
    logic       rdy_r;         // ready flag
    logic [4:0] set_cnt_r;     // settling counter
    logic [4:0] os_cnt_r;      // one-shot counter
    logic       go_d_r;        // run delayed
    logic [1:0] rs_r, fs_r;    // input synchronisers
    logic       rq_r, fq_r;    // previous synced inputs
    logic       dir_r;         // alternate direction: 1 rising
    logic       ramp_r;        // ramp running (non-alt modes)
    // sleep_in is deliberately unread: operation ignores sleep
    // ========================================
    // bus decode
    wire acc      = psel & penable;
    wire hit_main = (paddr == RGC_OFS_MAIN);
    wire hit_pol  = (paddr == RGC_OFS_STPOL);
    wire wr_main  = acc & pwrite & hit_main;
    wire wr_pol   = acc & pwrite & hit_pol;
    assign pready  = 1'b1;
    assign pslverr = acc & ~(hit_main | hit_pol);
    // ========================================
    // field views
    wire en     = main_r[RGC_EN_BIT];
    wire go     = main_r[RGC_GO_BIT];
    wire os_en  = main_r[RGC_OS_BIT];
    wire fall_trigger_edge_select   = main_r[RGC_FALL_TRIGGER_EDGE_SELECT_BIT];
    wire rise_trigger_edge_select   = main_r[RGC_RISE_TRIGGER_EDGE_SELECT_BIT];
    wire [1:0] mode = main_r[RGC_MODE_LSB +: 2];
    wire alt    = (mode == RGC_MODE_ALT);
    // masked write: bit 6 dropped, run forced low if disabled
    wire [7:0] wmain = pwdata[7:0] & RGC_MAIN_WMASK;
    wire [7:0] main_nxt = wmain[RGC_EN_BIT] ? wmain :
                          (wmain & ~8'h01);
    // ========================================
    // timing input conditioning
    wire r_lvl = rs_r[1] ^ pol_r[RGC_RISE_TRIGGER_POLARITY_BIT];
    wire f_lvl = fs_r[1] ^ pol_r[RGC_FALL_TRIGGER_POLARITY_BIT];
    wire r_edge = r_lvl & ~rq_r;
    wire f_edge = f_lvl & ~fq_r;
    wire os_act = (os_cnt_r != 5'h0_0);
    wire r_ev = ~os_act & (rise_trigger_edge_select ? r_edge : r_lvl);
    wire f_ev = ~os_act & (fall_trigger_edge_select ? f_edge : f_lvl);
    wire f_win = f_ev;
    wire r_win = r_ev & ~f_ev;
    wire run    = en & go;
    wire go_up  = run & ~go_d_r;
    // one-shot start: run rise, a discharge in the single-slope
    // modes, or a slope reversal in the alternating mode; a held
    // level must not keep retriggering the discharge
    wire os_rev  = alt ? ((f_win & dir_r) | (r_win & ~dir_r))
                       : (f_win & ramp_r);
    wire os_trig = os_en & (go_up | (run & os_rev));
    // ========================================
    // register file
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            main_r <= RGC_MAIN_RST;
            pol_r  <= RGC_POL_RST;
        end else begin
            if (wr_main) begin
                main_r <= main_nxt;
            end
            if (wr_pol) begin
                pol_r <= pwdata[1:0];
            end
        end
    end
    // read mux, bits above field width read zero
    wire [7:0] rd_pol = {5'h0_0, rdy_r, pol_r};
    wire [7:0] rd_sel = hit_main ? main_r : (hit_pol ? rd_pol : 8'h00);
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= {24'h00_0000, rd_sel};
        end
    end
    // ========================================
    // ready flag after settle count
    always_ff @(posedge sys_clk) begin
        if (!nrst || !en) begin
            set_cnt_r <= RGC_SET_LOAD;
            rdy_r     <= 1'b0;
        end else if (set_cnt_r != 5'h0_0) begin
            set_cnt_r <= set_cnt_r - 5'h0_1;
        end else begin
            rdy_r <= 1'b1;
        end
    end
    // ========================================
    // input sync and edge history
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rs_r <= 2'h0;
            fs_r <= 2'h0;
            rq_r <= 1'b0;
            fq_r <= 1'b0;
        end else begin
            rs_r <= {rs_r[0], set_rise_in};
            fs_r <= {fs_r[0], set_fall_in};
            rq_r <= r_lvl;
            fq_r <= f_lvl;
        end
    end
    // ========================================
    // one-shot counter
    always_ff @(posedge sys_clk) begin
        if (!nrst || !en) begin
            os_cnt_r <= 5'h0_0;
            go_d_r   <= 1'b0;
        end else begin
            go_d_r <= run;
            if (os_trig) begin
                os_cnt_r <= RGC_OS_LOAD;
            end else if (os_act) begin
                os_cnt_r <= os_cnt_r - 5'h0_1;
            end
        end
    end
    // ========================================
    // ramp state
    always_ff @(posedge sys_clk) begin
        if (!nrst || !run) begin
            dir_r  <= 1'b1;
            ramp_r <= 1'b0;
        end else if (f_win) begin
            dir_r  <= 1'b0;
            ramp_r <= 1'b0;
        end else if (r_win) begin
            dir_r  <= 1'b1;
            ramp_r <= 1'b1;
        end
    end
    // ========================================
    // switch outputs
    wire gate_os = os_en & os_act;
    always_comb begin
        analog_en = en;
        src_sw    = 1'b0;
        sink_sw   = 1'b0;
        dis_sw    = en;
        if (run) begin
            if (alt) begin
                src_sw  = dir_r;
                sink_sw = ~dir_r;
                dis_sw  = 1'b0;
            end else if (mode == RGC_MODE_SLOPE ||
                         mode == RGC_MODE_RISE) begin
                dis_sw  = ~ramp_r | gate_os;
                sink_sw = (mode == RGC_MODE_SLOPE) & ~dis_sw;
                src_sw  = (mode == RGC_MODE_RISE) & ~dis_sw;
            end
        end
    end
    // ========================================
    // checks
    // run bit never stored while disabled
    run_gate_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !main_r[RGC_EN_BIT] |-> !main_r[RGC_GO_BIT])
        else $error("run set while disabled");
    // enabled but stopped: discharge closed, sources open
    idle_dis_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (en && !go) |-> (dis_sw && !src_sw && !sink_sw))
        else $error("idle switches wrong");
    // ready drops one cycle after disable
    rdy_off_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !en |=> !rdy_r)
        else $error("ready while disabled");
    // run rise holds the discharge switch outside the alternating mode
    os_hold_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (os_en && go_up && mode != RGC_MODE_ALT) |=> dis_sw)
        else $error("one-shot did not hold discharge");
    // simultaneous events: falling wins
    fall_prio_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (run && f_ev && r_ev && alt) |=> !dir_r)
        else $error("rise beat fall");
    // unimplemented bit stays zero
    rsvd_zero_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        main_r[6] == 1'b0)
        else $error("reserved bit set");
    // no event accepted while the one-shot runs
    edge_block_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        os_act |-> (!r_ev && !f_ev))
        else $error("event during one-shot");
    // rise event turns the alternating ramp upward
    alt_dir_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (run && alt && r_win) |=> (run && alt) |-> src_sw)
        else $error("no rise after rise event");
    // ========================================
    // one-shot timing checks
    // a trigger loads the full one-shot count
    os_load_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        os_trig |=> (os_cnt_r == RGC_OS_LOAD))
        else $error("one-shot count not loaded");
    // the count steps down by one each cycle
    os_count_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (en && os_act && !os_trig)
        |=> (os_cnt_r == $past(os_cnt_r) - 5'h0_1))
        else $error("one-shot count skipped");
    // minimum time off: no one-shot is started
    os_off_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !os_en |-> !os_trig)
        else $error("one-shot started while off");
    // run rise starts the one-shot
    go_os_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (os_en && go_up) |=> os_act)
        else $error("run rise missed one-shot");
    // ramp state frozen while the one-shot runs
    os_freeze_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (os_act && run) |=> (ramp_r == $past(ramp_r) &&
                             dir_r == $past(dir_r)))
        else $error("ramp moved during one-shot");
    // ========================================
    // input conditioning checks
    // rise edge lasts exactly one cycle
    r_pulse_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        r_edge |=> !r_edge)
        else $error("rise edge longer than a cycle");
    // fall edge lasts exactly one cycle
    f_pulse_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        f_edge |=> !f_edge)
        else $error("fall edge longer than a cycle");
    // falling event ends a single-slope ramp
    fall_end_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (run && !alt && f_win) |=> !ramp_r)
        else $error("ramp kept after fall event");
    // rising event starts a single-slope ramp
    rise_go_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (run && !alt && r_win) |=> ramp_r)
        else $error("ramp not started");
    // ========================================
    // switch checks
    // without the one-shot a fall closes discharge directly
    dis_direct_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (run && !os_en && !alt && f_win) |=> (run && !alt) |-> dis_sw)
        else $error("discharge not closed on fall");
    // rising ramp mode uses the source only
    rise_src_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (run && mode == RGC_MODE_RISE && ramp_r && !os_act)
        |-> (src_sw && !sink_sw && !dis_sw))
        else $error("rising ramp switches wrong");
    // slope mode uses the sink only
    slope_sink_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (run && mode == RGC_MODE_SLOPE && ramp_r && !os_act)
        |-> (sink_sw && !src_sw && !dis_sw))
        else $error("slope switches wrong");
    // reserved mode drives no current
    rsvd_mode_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (run && mode == 2'h3) |-> (!src_sw && !sink_sw))
        else $error("reserved mode drove current");
    // alternating mode: exactly one of source and sink
    alt_excl_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (run && alt) |-> (src_sw != sink_sw && !dis_sw))
        else $error("alternating switches wrong");
    // disabled: every switch and the bias off
    off_all_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !en |-> !(analog_en || src_sw || sink_sw || dis_sw))
        else $error("output active while disabled");
    // ========================================
    // ready and reset checks
    // ready rises once the settle count is spent
    rdy_set_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (en && set_cnt_r == 5'h0_0) |=> rdy_r)
        else $error("ready late");
    // ready stays low while settling
    rdy_wait_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (set_cnt_r != 5'h0_0) |-> !rdy_r)
        else $error("ready early");
    // reset clears every control field
    rst_clr_a: assert property (
        @(posedge sys_clk)
        !nrst |=> (main_r == RGC_MAIN_RST && pol_r == RGC_POL_RST &&
                   !rdy_r))
        else $error("reset left a field set");
endmodule : rgc_top
